/* File: socket_decode_pkg.sv */
// Constants and carrier types for the socket register space decoder.
// Assumes a PCI target front end on the same clock hands over decoded cycles.
package socket_decode_pkg;

  // ----------------------------------------
  // Configuration space layout
  // ----------------------------------------
  localparam logic [7:0] CFG_HDR_END = 8'h40;
  localparam logic [7:0] CFG_SOCK_END = 8'hC0;
  localparam logic [1:0] CFG_FUNC_HI = 2'h0;

  // ----------------------------------------
  // Memory window layout
  // ----------------------------------------
  localparam logic [11:0] WIN_HALF = 12'h800;
  localparam logic [11:0] CB_LOCAL_END = 12'h020;
  localparam logic [11:0] PC16_END = 12'h840;
  localparam logic [11:0] EVT_OFS = 12'h000;
  localparam logic [11:0] PRS_OFS = 12'h008;

  // ----------------------------------------
  // Legacy index/data ports
  // ----------------------------------------
  localparam logic [15:0] LEG_BASE0 = 16'h03E0;
  localparam logic [15:0] LEG_BASE1 = 16'h03E2;
  localparam int LEG_SOCK_BIT = 6;
  localparam int LEG_BAD_BIT = 7;
  localparam logic [7:0] LEG_INDEX_RST = 8'h00;

  // ----------------------------------------
  // Pin synchroniser layout and reset values
  // ----------------------------------------
  localparam int PIN_SUSP = 0;
  localparam int PIN_RST = 1;
  localparam int PIN_SIRQ = 2;
  localparam logic [2:0] PIN_RST_VAL = 3'h3;
  localparam logic [7:0] CARD_RST_VAL = 8'hF0;
  localparam int EVT_STSCHG = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_DETECT = 2;

  typedef enum logic [1:0] {
    SP_CFG = 2'b00,
    SP_MEM = 2'b01,
    SP_IO = 2'b10
  } space_t;

  typedef enum logic [2:0] {
    RG_NONE = 3'b000,
    RG_HDR = 3'b001,
    RG_SOCKCFG = 3'b010,
    RG_CB32 = 3'b011,
    RG_PC16 = 3'b100
  } region_t;

  typedef struct packed {
    logic valid;
    space_t space;
    logic primary;
    logic write;
    logic [2:0] func;
    logic [1:0] barHit;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } req_t;

  typedef struct packed {
    logic valid;
    region_t region;
    logic sock;
    logic [11:0] offset;
    logic write;
    logic [31:0] wdata;
    logic [3:0] be;
  } fwd_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } rsp_t;

endpackage

/* File: socket_register_space_decode.sv */
// Address decode for the per-socket configuration, window and legacy spaces,
// plus suspend gating of the host reset, and the interrupt mode and video select outputs.
// Assumes requests arrive on clk_sys from a PCI target front end; card and
// system pins are asynchronous and are synchronised here.
//
// Notes on behaviour
// - Each socket owns a 256-byte configuration space picked by its function.
// - Configuration offsets below 64 bytes go to the standard bridge header.
// - Configuration offsets 40h to BFh (128 bytes) go to socket-specific control logic.
// - Configuration cycles are claimed only when they come from the primary bus.
// - The block looks like one device with one secondary bus per socket.
// - A per-socket base address hit locates a 4 KB window of card registers.
// - Offsets below 20h in the lower 2 KB of the window select the 32-bit card registers.
// - Offsets 800h to 83Fh (64 bytes) in the upper 2 KB select the 16-bit card registers.
// - Card control registers latch status change and wake events and show presence.
// - In legacy mode the 16-bit registers are reached via index and data I/O ports.
// - While hardware suspend is asserted the host bus reset is ignored.
// - The video select output is low when both sockets' video enable bits are 0.
// - The serial interrupt select pin picks serialised or parallel interrupts.
// - Interrupt line nine becomes the serial line on the select pin or enable bit.
`timescale 1ns/1ps

module socket_register_space_decode (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire socket_decode_pkg::req_t req,
  input wire logic legacyMode,
  input wire logic serialIrqEnable,
  input wire logic [1:0] videoPortEnable,
  input wire logic hardwareSuspendN,
  input wire logic hostBusResetN,
  input wire logic serialIrqPinSelect,
  input wire logic [1:0] cardStatusChange,
  input wire logic [1:0] remoteWake,
  input wire logic [3:0] cardDetectN,
  output socket_decode_pkg::fwd_t fwd,
  output socket_decode_pkg::rsp_t rsp,
  output logic hostResetAccepted,
  output logic serializedIrqMode,
  output logic videoPortSelectN
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pinSync1;
  logic [2:0] pinSync2;
  logic [7:0] cardSync1;
  logic [7:0] cardSync2;
  logic [7:0] cardPrev;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pinSync1 <= socket_decode_pkg::PIN_RST_VAL;
      pinSync2 <= socket_decode_pkg::PIN_RST_VAL;
      cardSync1 <= socket_decode_pkg::CARD_RST_VAL;
      cardSync2 <= socket_decode_pkg::CARD_RST_VAL;
      cardPrev <= socket_decode_pkg::CARD_RST_VAL;
    end
    else
    begin
      pinSync1 <= {serialIrqPinSelect, hostBusResetN, hardwareSuspendN};
      pinSync2 <= pinSync1;
      cardSync1 <= {cardDetectN, remoteWake, cardStatusChange};
      cardSync2 <= cardSync1;
      cardPrev <= cardSync2;
    end
  end

  // ----------------------------------------
  // Per-socket event detection
  // ----------------------------------------
  logic [1:0][2:0] newEvt;
  logic [1:0] present;

  for (genvar s = 0; s < 2; s++)
  begin : g_sock
    logic presPrev;
    assign present[s] = ~cardSync2[4 + 2 * s] & ~cardSync2[5 + 2 * s];
    assign presPrev = ~cardPrev[4 + 2 * s] & ~cardPrev[5 + 2 * s];
    // Edges of change, wake and detect
    assign newEvt[s][socket_decode_pkg::EVT_STSCHG] = cardSync2[s] & ~cardPrev[s];
    assign newEvt[s][socket_decode_pkg::EVT_WAKE] = cardSync2[2 + s] & ~cardPrev[2 + s];
    assign newEvt[s][socket_decode_pkg::EVT_DETECT] = present[s] ^ presPrev;
  end

  // ----------------------------------------
  // Decode and local registers
  // ----------------------------------------
  logic [1:0][2:0] evt;
  logic [7:0] legIndex;
  socket_decode_pkg::fwd_t next_fwd;
  socket_decode_pkg::rsp_t next_rsp;
  logic [1:0][2:0] next_evt;
  logic [7:0] next_legIndex;
  logic next_hostResetAccepted;
  logic next_serializedIrqMode;
  logic next_videoPortSelectN;

  always_comb
  begin
    logic [1:0][2:0] clr;
    logic sock;
    logic [11:0] off;
    clr = '0;
    sock = 1'b0;
    off = req.addr[11:0];
    next_fwd = '0;
    next_rsp = '0;
    next_legIndex = legIndex;
    // Host reset counts only while not suspended
    next_hostResetAccepted = ~pinSync2[socket_decode_pkg::PIN_RST]
      & pinSync2[socket_decode_pkg::PIN_SUSP];
    // Line nine serialised by pin or enable bit
    next_serializedIrqMode = pinSync2[socket_decode_pkg::PIN_SIRQ] | serialIrqEnable;
    // Low only when both enables are clear
    next_videoPortSelectN = |videoPortEnable;
    next_fwd.write = req.write;
    next_fwd.wdata = req.wdata;
    next_fwd.be = req.be;
    if (!req.valid)
    begin
      next_fwd.valid = 1'b0;
    end
    // Primary bus only, functions 0 and 1
    else if (req.space == socket_decode_pkg::SP_CFG && req.primary
      && req.func[2:1] == socket_decode_pkg::CFG_FUNC_HI)
    begin
      next_fwd.sock = req.func[0];
      next_fwd.offset = {4'h0, req.addr[7:0]};
      if (req.addr[7:0] < socket_decode_pkg::CFG_HDR_END)
      begin
        next_fwd.valid = 1'b1;
        next_fwd.region = socket_decode_pkg::RG_HDR;
      end
      else if (req.addr[7:0] < socket_decode_pkg::CFG_SOCK_END)
      begin
        next_fwd.valid = 1'b1;
        next_fwd.region = socket_decode_pkg::RG_SOCKCFG;
      end
      else
      begin
        next_rsp.ack = 1'b1;
      end
    end
    // Base address hit picks the socket
    else if (req.space == socket_decode_pkg::SP_MEM && |req.barHit)
    begin
      sock = req.barHit[1];
      next_fwd.sock = sock;
      next_fwd.offset = off;
      // Lower half is 32-bit card space
      if (off < socket_decode_pkg::WIN_HALF)
      begin
        // Sticky events, write one to clear
        if (off == socket_decode_pkg::EVT_OFS)
        begin
          next_rsp.ack = 1'b1;
          next_rsp.rdata = {29'h0000000, evt[sock]};
          if (req.write && req.be[0])
          begin
            clr[sock] = req.wdata[2:0];
          end
        end
        else if (off == socket_decode_pkg::PRS_OFS)
        begin
          next_rsp.ack = 1'b1;
          next_rsp.rdata = {31'h00000000, present[sock]};
        end
        else if (off < socket_decode_pkg::CB_LOCAL_END)
        begin
          next_fwd.valid = 1'b1;
          next_fwd.region = socket_decode_pkg::RG_CB32;
        end
        else
        begin
          next_rsp.ack = 1'b1;
        end
      end
      // Upper half is 16-bit card space
      else if (off < socket_decode_pkg::PC16_END)
      begin
        next_fwd.valid = 1'b1;
        next_fwd.region = socket_decode_pkg::RG_PC16;
      end
      else
      begin
        next_rsp.ack = 1'b1;
      end
    end
    else if (req.space == socket_decode_pkg::SP_IO && legacyMode
      && (req.addr[15:1] == socket_decode_pkg::LEG_BASE0[15:1]
      || req.addr[15:1] == socket_decode_pkg::LEG_BASE1[15:1]))
    begin
      if (!req.addr[0])
      begin
        next_rsp.ack = 1'b1;
        next_rsp.rdata = {24'h000000, legIndex};
        if (req.write && req.be[0])
        begin
          next_legIndex = req.wdata[7:0];
        end
      end
      else if (legIndex[socket_decode_pkg::LEG_BAD_BIT])
      begin
        next_rsp.ack = 1'b1;
      end
      else
      begin
        next_fwd.valid = 1'b1;
        next_fwd.region = socket_decode_pkg::RG_PC16;
        next_fwd.sock = legIndex[socket_decode_pkg::LEG_SOCK_BIT];
        next_fwd.offset = 12'(socket_decode_pkg::WIN_HALF + {6'h00, legIndex[5:0]});
      end
    end
    // Set wins over clear
    for (int s = 0; s < 2; s++)
    begin
      next_evt[s] = (evt[s] & ~clr[s]) | newEvt[s];
    end
    // Accepted host reset clears local state
    if (hostResetAccepted)
    begin
      next_evt = '0;
      next_legIndex = socket_decode_pkg::LEG_INDEX_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      fwd <= '0;
      rsp <= '0;
      evt <= '0;
      legIndex <= socket_decode_pkg::LEG_INDEX_RST;
      hostResetAccepted <= 1'b0;
      serializedIrqMode <= 1'b0;
      videoPortSelectN <= 1'b0;
    end
    else
    begin
      fwd <= next_fwd;
      rsp <= next_rsp;
      evt <= next_evt;
      legIndex <= next_legIndex;
      hostResetAccepted <= next_hostResetAccepted;
      serializedIrqMode <= next_serializedIrqMode;
      videoPortSelectN <= next_videoPortSelectN;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_cfg_primary_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.valid && req.space == socket_decode_pkg::SP_CFG && !req.primary
    |=> !fwd.valid && !rsp.ack)
    else $error("config cycle claimed from non-primary bus");

  a_cfg_header_route: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.valid && req.space == socket_decode_pkg::SP_CFG && req.primary
    && req.func[2:1] == 2'h0 && req.addr[7:0] < 8'h40
    |=> fwd.valid && fwd.region == socket_decode_pkg::RG_HDR)
    else $error("header offset not routed to header");

  a_cfg_socket_route: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.valid && req.space == socket_decode_pkg::SP_CFG && req.primary
    && req.func[2:1] == 2'h0 && req.addr[7:0] >= 8'h40 && req.addr[7:0] < 8'hC0
    |=> fwd.region == socket_decode_pkg::RG_SOCKCFG && fwd.sock == $past(req.func[0]))
    else $error("socket config offset misrouted");

  a_win_upper_half: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.valid && req.space == socket_decode_pkg::SP_MEM && |req.barHit
    && req.addr[11:0] >= 12'h800 && req.addr[11:0] < 12'h840
    |=> fwd.valid && fwd.region == socket_decode_pkg::RG_PC16)
    else $error("upper window half not routed to 16-bit space");

  a_win_unused_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    req.valid && req.space == socket_decode_pkg::SP_MEM && |req.barHit
    && req.addr[11:0] >= 12'h020 && req.addr[11:0] < 12'h800
    |=> rsp.ack && rsp.rdata == 32'h00000000 && !fwd.valid)
    else $error("unused offset not answered with zero");

  a_suspend_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    !pinSync2[socket_decode_pkg::PIN_SUSP] |=> !hostResetAccepted)
    else $error("host reset accepted during suspend");

  a_video_select: assert property (@(posedge clk_sys) disable iff (!nrst)
    videoPortEnable == 2'h0 |=> !videoPortSelectN)
    else $error("video select not low with both enables clear");

  a_serial_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pinSync2[socket_decode_pkg::PIN_SIRQ] || serialIrqEnable) |=> serializedIrqMode)
    else $error("line nine not serialised");

  a_event_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
    newEvt[0][0] && !hostResetAccepted |=> evt[0][0])
    else $error("status change event lost");

endmodule // socket_register_space_decode

/* File: host_chipset_model.sv */
// Host bus master and chipset model driving the decoder's request and system pins.
// Assumes the bench calls its tasks; every task drive follows a clk_sys rising edge.
`timescale 1ns/1ps

module host_chipset_model (
  input wire logic clk_sys,
  output socket_decode_pkg::req_t req,
  output logic hardwareSuspendN,
  output logic serialIrqPinSelect
);
  initial
  begin
    req = '0;
    hardwareSuspendN = 1'b1;
    serialIrqPinSelect = 1'b0;
  end

  // One request pulse; released fields go inverted so stale values are not read
  task automatic send(input logic [1:0] sp, input logic pri, input logic [2:0] fn,
    input logic [1:0] bar, input logic [15:0] ad, input logic [31:0] wd, input logic wr);
    socket_decode_pkg::req_t r;
    r = '{1'b1, socket_decode_pkg::space_t'(sp), pri, wr, fn, bar, ad, wd, 4'hF};
    @(posedge clk_sys);
    req <= r;
    @(posedge clk_sys);
    r = ~r;
    r.valid = 1'b0;
    req <= r;
    #1;
  endtask

  task automatic enter_suspend();
    @(posedge clk_sys);
    serialIrqPinSelect <= 1'b0;
    repeat (4) @(posedge clk_sys);
    hardwareSuspendN <= 1'b0;
  endtask

  task automatic leave_suspend();
    @(posedge clk_sys);
    hardwareSuspendN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    serialIrqPinSelect <= 1'b1;
  endtask

  task automatic set_serial(input logic v);
    @(posedge clk_sys);
    serialIrqPinSelect <= v;
  endtask
endmodule // host_chipset_model

/* File: socket_register_space_decode_tb.sv */
// Self-checking bench for the socket register space decoder.
// Assumes the host model drives requests, the suspend pin and the serial interrupt select pin; the bench drives the rest.
`timescale 1ns/1ps

module socket_register_space_decode_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic legacyMode = 1'b0;
  logic serialIrqEnable = 1'b0;
  logic hostBusResetN = 1'b1;
  logic [1:0] videoPortEnable = 2'h0;
  logic [1:0] cardStatusChange = 2'h0;
  logic [1:0] remoteWake = 2'h0;
  logic [3:0] cardDetectN = 4'hF;
  logic hardwareSuspendN;
  logic serialIrqPinSelect;
  logic hostResetAccepted;
  logic serializedIrqMode;
  logic videoPortSelectN;
  socket_decode_pkg::req_t req;
  socket_decode_pkg::fwd_t fwd;
  socket_decode_pkg::rsp_t rsp;
  int n_errors = 0;
  int comparisons = 0;

  always #2.5 clk_sys = ~clk_sys;

  host_chipset_model u_host (
    .clk_sys(clk_sys),
    .req(req),
    .hardwareSuspendN(hardwareSuspendN),
    .serialIrqPinSelect(serialIrqPinSelect)
  );

  socket_register_space_decode u_dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .req(req),
    .legacyMode(legacyMode),
    .serialIrqEnable(serialIrqEnable),
    .videoPortEnable(videoPortEnable),
    .hardwareSuspendN(hardwareSuspendN),
    .hostBusResetN(hostBusResetN),
    .serialIrqPinSelect(serialIrqPinSelect),
    .cardStatusChange(cardStatusChange),
    .remoteWake(remoteWake),
    .cardDetectN(cardDetectN),
    .fwd(fwd),
    .rsp(rsp),
    .hostResetAccepted(hostResetAccepted),
    .serializedIrqMode(serializedIrqMode),
    .videoPortSelectN(videoPortSelectN)
  );

  // ----------------------------------------
  // Comparison and answer helpers
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // Target fields only carry meaning while fwd.valid stands
  function automatic logic [63:0] ans();
    logic [15:0] tgt;
    tgt = fwd.valid ? {fwd.region, fwd.sock, fwd.offset} : 16'h0000;
    return {14'h0, fwd.valid, tgt, rsp.ack, rsp.rdata};
  endfunction

  function automatic logic [63:0] fw(input logic [2:0] r, input logic s, input logic [11:0] o);
    return {14'h0, 1'b1, r, s, o, 33'h0};
  endfunction

  function automatic logic [63:0] ak(input logic [31:0] d);
    return {31'h0, 1'b1, d};
  endfunction

  task automatic rq(input logic [1:0] sp, input logic pri, input logic [2:0] fn,
    input logic [1:0] bar, input logic [15:0] a, input logic [31:0] wd, input logic [63:0] e);
    u_host.send(sp, pri, fn, bar, a, wd, wd != 32'h0);
    check(ans(), e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_config();
    rq(2'h0, 1'b1, 3'h0, 2'h0, 16'h003F, 32'h0, fw(3'h1, 1'b0, 12'h03F));
    rq(2'h0, 1'b1, 3'h1, 2'h0, 16'h0040, 32'h0, fw(3'h2, 1'b1, 12'h040));
    rq(2'h0, 1'b1, 3'h0, 2'h0, 16'h00BF, 32'h0, fw(3'h2, 1'b0, 12'h0BF));
    rq(2'h0, 1'b1, 3'h1, 2'h0, 16'h00C4, 32'h0, ak(32'h0));
    rq(2'h0, 1'b0, 3'h0, 2'h0, 16'h0010, 32'h0, 64'h0);
    rq(2'h0, 1'b1, 3'h2, 2'h0, 16'h0010, 32'h0, 64'h0);
  endtask

  task automatic t_window();
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h001C, 32'h0, fw(3'h3, 1'b0, 12'h01C));
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h0020, 32'h0, ak(32'h0));
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h07FC, 32'h0, ak(32'h0));
    rq(2'h1, 1'b1, 3'h0, 2'h2, 16'h0800, 32'h0, fw(3'h4, 1'b1, 12'h800));
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h0804, 32'hA5A50F0F, fw(3'h4, 1'b0, 12'h804));
    check({27'h0, fwd.write, fwd.be, fwd.wdata}, {27'h0, 1'b1, 4'hF, 32'hA5A50F0F});
    rq(2'h1, 1'b1, 3'h0, 2'h3, 16'h083C, 32'h0, fw(3'h4, 1'b1, 12'h83C));
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h0840, 32'h0, ak(32'h0));
    rq(2'h1, 1'b1, 3'h0, 2'h0, 16'h0804, 32'h0, 64'h0);
  endtask

  task automatic t_legacy();
    @(posedge clk_sys);
    legacyMode <= 1'b1;
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E0, 32'h45, ak(32'h0));
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E1, 32'h0, fw(3'h4, 1'b1, 12'h805));
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E0, 32'h83, ak(32'h45));
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E1, 32'h0, ak(32'h0));
    @(posedge clk_sys);
    legacyMode <= 1'b0;
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E1, 32'h0, 64'h0);
  endtask

  task automatic t_events();
    @(posedge clk_sys);
    cardDetectN <= 4'hC;
    cardStatusChange <= 2'h1;
    remoteWake <= 2'h2;
    repeat (8) @(posedge clk_sys);
    cardStatusChange <= 2'h0;
    remoteWake <= 2'h0;
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h0000, 32'h0, ak(32'h5));
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h0008, 32'h0, ak(32'h1));
    rq(2'h1, 1'b1, 3'h0, 2'h2, 16'h0000, 32'h0, ak(32'h2));
    rq(2'h1, 1'b1, 3'h0, 2'h2, 16'h0008, 32'h0, ak(32'h0));
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h0000, 32'h7, ak(32'h5));
    rq(2'h1, 1'b1, 3'h0, 2'h1, 16'h0000, 32'h0, ak(32'h0));
  endtask

  task automatic t_pins();
    @(posedge clk_sys);
    hostBusResetN <= 1'b0;
    legacyMode <= 1'b1;
    settle(5);
    check(64'(hostResetAccepted), 64'h1);
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E2, 32'h0, ak(32'h0));
    @(posedge clk_sys);
    hostBusResetN <= 1'b1;
    u_host.enter_suspend();
    @(posedge clk_sys);
    hostBusResetN <= 1'b0;
    settle(5);
    check(64'(hostResetAccepted), 64'h0);
    check(64'(serializedIrqMode), 64'h0);
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E2, 32'h12, ak(32'h0));
    rq(2'h2, 1'b1, 3'h0, 2'h0, 16'h03E2, 32'h0, ak(32'h12));
    @(posedge clk_sys);
    hostBusResetN <= 1'b1;
    u_host.leave_suspend();
    settle(5);
    check(64'(serializedIrqMode), 64'h1);
    u_host.set_serial(1'b0);
    serialIrqEnable <= 1'b1;
    settle(5);
    check(64'(serializedIrqMode), 64'h1);
    @(posedge clk_sys);
    serialIrqEnable <= 1'b0;
    settle(5);
    check(64'(serializedIrqMode), 64'h0);
  endtask

  task automatic t_video();
    for (int v = 0; v < 4; v++)
    begin
      @(posedge clk_sys);
      videoPortEnable <= v[1:0];
      settle(2);
      check(64'(videoPortSelectN), 64'(v != 0));
    end
  endtask

  // ----------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_config();
    t_window();
    t_legacy();
    t_events();
    t_pins();
    t_video();
    print_verdict();
  end

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule // socket_register_space_decode_tb
